// ### core/serial_if_pkg.sv
/*
  Constants for the synchronous-capable serial channel: register indices,
  field positions, reset values, pin function code and bit timing.
  Assumes a 32-bit APB register bus; a register's byte address is four
  times its index, taken modulo 2**32.
*/
package serial_if_pkg;

  // ************************************************************
  // Register indices (byte address = index * 4, 32-bit wrap)
  // ************************************************************
  localparam logic [31:0] IDX_MODE = 32'hFFFF81C0;   // serial_mode_reg
  localparam logic [31:0] IDX_DIV = 32'hFFFF81C1;    // bit_rate_divider
  localparam logic [31:0] IDX_CTRL = 32'hFFFF81C2;   // Enables
  localparam logic [31:0] IDX_TXBYTE = 32'hFFFF81C3; // transmit_byte_reg
  localparam logic [31:0] IDX_STAT = 32'hFFFF81C4;   // serial_status_reg
  localparam logic [31:0] IDX_RXBYTE = 32'hFFFF81C5; // receive_byte_reg
  localparam logic [31:0] IDX_ORDER = 32'hFFFF81C6;  // bit_order_control
  localparam logic [31:0] IDX_PDIR = 32'hFFFF8386;   // port_a_direction_low
  localparam logic [31:0] IDX_PFN3 = 32'hFFFF838A;   // port_a_function_low3
  localparam logic [31:0] IDX_PFN2 = 32'hFFFF838E;   // port_a_function_low2

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MODE_SYNC_BIT = 7;
  localparam int MODE_LEN_BIT = 6;
  localparam int MODE_PAR_BIT = 5;
  localparam int MODE_ODD_BIT = 4;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_MULTI_BIT = 2;
  localparam int MODE_CLKSEL_LSB = 0;
  localparam int CTRL_TXEN_BIT = 5;
  localparam int CTRL_RXEN_BIT = 4;
  localparam int ORDER_DIR_BIT = 3;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_PARITY_ERR = 3;
  localparam int ST_TX_DONE = 2;
  localparam int ST_MULTI_RX = 1;
  localparam int ST_MULTI_TX = 0;
  localparam int PIN_SCK = 2;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'hFF;
  localparam logic [7:0] STAT_RST = 8'h84;
  localparam logic [7:0] ORDER_RST = 8'h00;
  localparam logic [15:0] PORT_RST = 16'h0000;
  localparam logic [2:0] PIN_FUNC_SERIAL = 3'b110;

  // ************************************************************
  // Bit timing: reference point 40 MHz, divider 9 -> 1 Mbps synchronous (async eight times slower)
  // ************************************************************
  localparam int REF_CLK_MHZ = 40;
  localparam int REF_DIVIDER = 9;
  localparam int REF_RATE_MBPS = 1;
  localparam int SYNC_TICKS_PER_BIT = REF_CLK_MHZ / (REF_RATE_MBPS * (REF_DIVIDER + 1));
  localparam int ASYNC_TICKS_PER_BIT = 8 * SYNC_TICKS_PER_BIT;
  localparam logic [1:0] SYNC_RISE_PH = 2'(SYNC_TICKS_PER_BIT / 2 - 1);
  localparam logic [1:0] SYNC_END_PH = 2'(SYNC_TICKS_PER_BIT - 1);
  localparam logic [4:0] ASYNC_MID_PH = 5'(ASYNC_TICKS_PER_BIT / 2 - 1);
  localparam logic [4:0] ASYNC_END_PH = 5'(ASYNC_TICKS_PER_BIT - 1);

  // ************************************************************
  // State encodings (Gray except the ARX_DATA to ARX_IDLE return)
  // ************************************************************
  typedef enum logic [1:0] {SYN_IDLE = 2'b00, SYN_RUN = 2'b01} syn_state_type;
  typedef enum logic [1:0] {ATX_IDLE = 2'b00, ATX_SHIFT = 2'b01} atx_state_type;
  typedef enum logic [1:0] {ARX_IDLE = 2'b00, ARX_START = 2'b01, ARX_DATA = 2'b11} arx_state_type;

endpackage

// ### core/serial_if.sv
/*
  Serial channel with clocked synchronous and asynchronous framing, its
  register file on APB, and the port A pin function routing for receive,
  transmit and serial clock.
  Assumes pins are synchronous to core_clk and the APB master is standard.
*/
// Added by the designer: the APB slave port.
// How it works
// - Mode bit 7 set selects clocked synchronous
// - Synchronous mode always moves eight-bit characters
// - Length bit 6 matters only in asynchronous
// - Parity bit 5 adds/checks parity, async only, not with bit 2 set
// - Parity mode bit 4 clear means even
// - Stop bit 3 clear sends one stop
// - Bit 2 enables multiprocessor bit, async only
// - Clock select 00 uses undivided clock
// - Divider sets rate; 9 at 40MHz gives 1Mbps synchronous, 125kbps async
// - Direction bit 3 clear means LSB first
// - Eight-bit transmit byte register for software
// - Eight-bit receive byte register holds last byte; after an overrun it keeps the older one
// - Status shows transmit register empty
// - Status shows receive register full
// - Pin 0 function 110 is receive input
// - Pin 1 function 110 is transmit output
// - Pin 2 function 110 carries serial clock
// - Direction bit 2 set drives clock out
// - Transmit only while transmit enable set; receive-only sync transfers still shift the transmit byte out
// - Receive only while receive enable set
`timescale 1ns/1ps

module serial_if (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe
);
  import serial_if_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] mode_ff;       // Framing and clock select
  logic [7:0] div_ff;        // Bit rate divider
  logic [7:0] ctrl_ff;       // Transmit and receive enables
  logic [7:0] txbyte_ff;     // Next byte to send
  logic [7:0] rxbyte_ff;     // Last byte accepted while not full
  logic [7:0] order_ff;      // Bit order
  logic [7:0] stat_ff;       // Flags
  logic [15:0] pdir_ff;      // Port direction
  logic [15:0] pfn3_ff;      // Port function, top mode bit
  logic [15:0] pfn2_ff;      // Port function, low mode bits
  logic [31:0] prdata_ff;    // Read data captured in setup phase
  logic [7:0] nxt_stat;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_mode = paddr == {IDX_MODE[29:0], 2'b00};
  wire hit_div = paddr == {IDX_DIV[29:0], 2'b00};
  wire hit_ctrl = paddr == {IDX_CTRL[29:0], 2'b00};
  wire hit_txbyte = paddr == {IDX_TXBYTE[29:0], 2'b00};
  wire hit_stat = paddr == {IDX_STAT[29:0], 2'b00};
  wire hit_rxbyte = paddr == {IDX_RXBYTE[29:0], 2'b00};
  wire hit_order = paddr == {IDX_ORDER[29:0], 2'b00};
  wire hit_pdir = paddr == {IDX_PDIR[29:0], 2'b00};
  wire hit_pfn3 = paddr == {IDX_PFN3[29:0], 2'b00};
  wire hit_pfn2 = paddr == {IDX_PFN2[29:0], 2'b00};
  wire hit_any = hit_mode | hit_div | hit_ctrl | hit_txbyte | hit_stat | hit_rxbyte | hit_order
                 | hit_pdir | hit_pfn3 | hit_pfn2;
  wire wr_en = access_ph && pwrite;
  wire rd_done = access_ph && !pwrite;
  wire [31:0] rd_mux = hit_mode ? {24'h0, mode_ff} :
                       hit_div ? {24'h0, div_ff} :
                       hit_ctrl ? {24'h0, ctrl_ff} :
                       hit_txbyte ? {24'h0, txbyte_ff} :
                       hit_stat ? {24'h0, stat_ff} :
                       hit_rxbyte ? {24'h0, rxbyte_ff} :
                       hit_order ? {24'h0, order_ff} :
                       hit_pdir ? {16'h0, pdir_ff} :
                       hit_pfn3 ? {16'h0, pfn3_ff} :
                       hit_pfn2 ? {16'h0, pfn2_ff} : 32'h0;
  // Zero wait states: every access completes in its first access cycle
  assign pready = access_ph;
  assign pslverr = access_ph && !hit_any;
  assign prdata = prdata_ff;

  // ************************************************************
  // Mode decode
  // ************************************************************
  wire sync_mode = mode_ff[MODE_SYNC_BIT];
  wire seven_bit = !sync_mode && mode_ff[MODE_LEN_BIT];
  wire par_en = !sync_mode && mode_ff[MODE_PAR_BIT] && !mode_ff[MODE_MULTI_BIT];
  wire par_odd = mode_ff[MODE_ODD_BIT];
  wire two_stop = mode_ff[MODE_STOP_BIT];
  wire multi_en = !sync_mode && mode_ff[MODE_MULTI_BIT];
  wire [1:0] clk_sel = mode_ff[MODE_CLKSEL_LSB +: 2];
  wire msb_first = order_ff[ORDER_DIR_BIT];
  wire tx_en = ctrl_ff[CTRL_TXEN_BIT];
  wire rx_en = ctrl_ff[CTRL_RXEN_BIT];
  wire [3:0] char_len = seven_bit ? 4'd7 : 4'd8;

  // ************************************************************
  // Pin function routing, one entry per pin
  // ************************************************************
  logic [2:0] pin_serial;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pinfn
      assign pin_serial[gi] = {pfn3_ff[gi], pfn2_ff[2*gi+1], pfn2_ff[2*gi]} == PIN_FUNC_SERIAL;
    end
  endgenerate
  wire rx_line = pin_serial[0] ? serial_rx_pin : 1'b1;
  wire sck_out_dir = pdir_ff[PIN_SCK];
  wire ext_clk = !sck_out_dir;
  wire sck_line = pin_serial[2] ? serial_clock_in : 1'b1;

  // Bit order applies within the character length
  function automatic logic [7:0] order_bits(input logic [7:0] d, input logic msb,
                                            input logic seven);
    logic [7:0] r;
    r = d;
    if (msb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = seven ? ((i < 7) ? d[6-i] : 1'b0) : d[7-i];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Baud tick: prescaler 4**n then divider + 1
  // ************************************************************
  logic [5:0] pre_cnt_ff;
  logic [7:0] div_cnt_ff;
  wire [5:0] pre_lim = (clk_sel == 2'b00) ? 6'd0 : (clk_sel == 2'b01) ? 6'd3 :
                       (clk_sel == 2'b10) ? 6'd15 : 6'd63;
  wire pre_en = pre_cnt_ff == pre_lim;
  wire baud_tick = pre_en && (div_cnt_ff == div_ff);

  // Free-running; a divider lowered below the count waits for an 8-bit wrap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= 6'd0;
      div_cnt_ff <= 8'd0;
    end else begin
      pre_cnt_ff <= pre_en ? 6'd0 : pre_cnt_ff + 6'd1;
      if (pre_en) begin
        div_cnt_ff <= baud_tick ? 8'd0 : div_cnt_ff + 8'd1;
      end
    end
  end

  // ************************************************************
  // Synchronous engine: 8 bits, no framing, one clock per bit
  // ************************************************************
  syn_state_type syn_state_ff;
  logic [7:0] syn_tx_ff;     // Outgoing bits, LSB on line
  logic [7:0] syn_rx_ff;     // Incoming bits, assembled at top
  logic [3:0] syn_cnt_ff;    // Rising edges seen
  logic [1:0] syn_ph_ff;     // Tick phase within a bit
  logic syn_sck_ff;          // Internal clock level, idles high
  logic sck_prev_ff;         // External clock history
  logic syn_txing_ff;        // This transfer carries transmit data
  wire syn_run = syn_state_ff == SYN_RUN;
  wire ext_rise = sck_line && !sck_prev_ff;
  wire ext_fall = !sck_line && sck_prev_ff;
  wire int_rise = baud_tick && syn_ph_ff == SYNC_RISE_PH;
  wire int_fall = baud_tick && syn_ph_ff == SYNC_END_PH;
  wire rise_ev = syn_run && (ext_clk ? ext_rise : int_rise);
  wire fall_ev = syn_run && (ext_clk ? ext_fall : int_fall);
  // Receive-only runs on internal clock stop while a byte is unread
  wire syn_want = (tx_en && !stat_ff[ST_TX_EMPTY])
                  || (rx_en && !tx_en && (ext_clk || !stat_ff[ST_RX_FULL]));
  // Internal clock waits for a tick so the first low half is full length
  wire syn_start = sync_mode && !syn_run && syn_want && (ext_clk || baud_tick);
  wire syn_done = syn_run && syn_cnt_ff == 4'd8 && (ext_clk || int_fall);
  wire [7:0] syn_rx_byte = order_bits(syn_rx_ff, msb_first, 1'b0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syn_state_ff <= SYN_IDLE;
      syn_tx_ff <= BYTE_RST;
      syn_rx_ff <= 8'h00;
      syn_cnt_ff <= 4'd0;
      syn_ph_ff <= 2'd0;
      syn_sck_ff <= 1'b1;
      syn_txing_ff <= 1'b0;
    end else if (syn_start) begin
      syn_state_ff <= SYN_RUN;
      syn_tx_ff <= order_bits(txbyte_ff, msb_first, 1'b0);
      syn_txing_ff <= tx_en;
      syn_cnt_ff <= 4'd0;
      syn_ph_ff <= 2'd0;
      syn_sck_ff <= ext_clk;
    end else if (syn_done) begin
      syn_state_ff <= SYN_IDLE;
      syn_sck_ff <= 1'b1;
    end else if (syn_run) begin
      if (baud_tick) begin
        syn_ph_ff <= syn_ph_ff + 2'd1;
      end
      if (!ext_clk && (int_rise || int_fall)) begin
        syn_sck_ff <= int_rise;
      end
      if (rise_ev) begin
        syn_rx_ff <= {rx_line, syn_rx_ff[7:1]};
        syn_cnt_ff <= syn_cnt_ff + 4'd1;
      end
      if (fall_ev && syn_cnt_ff != 4'd0) begin
        syn_tx_ff <= {1'b1, syn_tx_ff[7:1]};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_line;
    end
  end

  // ************************************************************
  // Asynchronous transmit frame builder
  // ************************************************************
  logic [11:0] atx_frame;
  logic [3:0] atx_nbits;
  logic [7:0] atx_data;
  logic atx_par;
  always_comb begin
    atx_data = order_bits(txbyte_ff, msb_first, seven_bit);
    atx_par = (^(seven_bit ? {1'b0, atx_data[6:0]} : atx_data)) ^ par_odd;
    atx_frame = 12'hFFF;
    atx_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < char_len) begin
        atx_frame[i+1] = atx_data[i];
      end
    end
    atx_nbits = char_len + 4'd1;
    if (par_en) begin
      atx_frame[atx_nbits] = atx_par;
      atx_nbits = atx_nbits + 4'd1;
    end
    if (multi_en) begin
      atx_frame[atx_nbits] = stat_ff[ST_MULTI_TX];
      atx_nbits = atx_nbits + 4'd1;
    end
    atx_nbits = atx_nbits + (two_stop ? 4'd2 : 4'd1);
  end

  // ************************************************************
  // Asynchronous transmitter
  // ************************************************************
  atx_state_type atx_state_ff;
  logic [11:0] atx_shift_ff;
  logic [3:0] atx_left_ff;
  logic [4:0] atx_ph_ff;
  wire atx_busy = atx_state_ff == ATX_SHIFT;
  wire atx_start = !sync_mode && tx_en && !atx_busy && !stat_ff[ST_TX_EMPTY];
  wire atx_bit_end = atx_busy && baud_tick && atx_ph_ff == ASYNC_END_PH;
  wire atx_done = atx_bit_end && atx_left_ff == 4'd1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      atx_state_ff <= ATX_IDLE;
      atx_shift_ff <= 12'hFFF;
      atx_left_ff <= 4'd0;
      atx_ph_ff <= 5'd0;
    end else if (atx_start) begin
      atx_state_ff <= ATX_SHIFT;
      atx_shift_ff <= atx_frame;
      atx_left_ff <= atx_nbits;
      atx_ph_ff <= 5'd0;
    end else if (atx_busy && baud_tick) begin
      atx_ph_ff <= atx_ph_ff + 5'd1;
      if (atx_bit_end) begin
        atx_shift_ff <= {1'b1, atx_shift_ff[11:1]};
        atx_left_ff <= atx_left_ff - 4'd1;
        atx_state_ff <= atx_done ? ATX_IDLE : ATX_SHIFT;
      end
    end
  end

  // ************************************************************
  // Asynchronous receiver: mid-bit sampling at half period
  // ************************************************************
  arx_state_type arx_state_ff;
  logic [11:0] arx_bits_ff;
  logic [3:0] arx_idx_ff;
  logic [4:0] arx_ph_ff;
  wire [3:0] arx_total = char_len + {3'd0, par_en} + {3'd0, multi_en};
  wire arx_sample = baud_tick && arx_ph_ff == ASYNC_END_PH;
  wire arx_done = arx_state_ff == ARX_DATA && arx_sample && arx_idx_ff == arx_total;
  wire [7:0] arx_raw = seven_bit ? {1'b0, arx_bits_ff[6:0]} : arx_bits_ff[7:0];
  wire [7:0] arx_byte = order_bits(arx_raw, msb_first, seven_bit);
  wire arx_extra = arx_bits_ff[char_len];
  wire arx_perr = par_en && ((^arx_raw) ^ par_odd) != arx_extra;
  wire arx_ferr = !rx_line;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arx_state_ff <= ARX_IDLE;
      arx_bits_ff <= 12'h000;
      arx_idx_ff <= 4'd0;
      arx_ph_ff <= 5'd0;
    end else begin
      case (arx_state_ff)
        ARX_IDLE: begin
          if (!sync_mode && rx_en && !rx_line) begin
            arx_state_ff <= ARX_START;
            arx_ph_ff <= 5'd0;
          end
        end
        ARX_START: begin
          if (baud_tick) begin
            arx_ph_ff <= arx_ph_ff + 5'd1;
          end
          // A start bit gone high by mid-bit was a glitch
          if (baud_tick && arx_ph_ff == ASYNC_MID_PH) begin
            arx_state_ff <= rx_line ? ARX_IDLE : ARX_DATA;
            arx_ph_ff <= 5'd0;
            arx_idx_ff <= 4'd0;
          end
        end
        ARX_DATA: begin
          if (baud_tick) begin
            arx_ph_ff <= arx_ph_ff + 5'd1;
          end
          if (arx_done) begin
            arx_state_ff <= ARX_IDLE;
          end else if (arx_sample) begin
            arx_bits_ff[arx_idx_ff] <= rx_line;
            arx_idx_ff <= arx_idx_ff + 4'd1;
          end
        end
        default: begin
          arx_state_ff <= ARX_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Flag events and status next value (set beats clear)
  // ************************************************************
  wire tx_load = (syn_start && tx_en) || atx_start;
  wire tx_end = (syn_done && syn_txing_ff) || atx_done;
  wire rx_got = (syn_done && rx_en) || arx_done;
  wire [7:0] rx_byte = sync_mode ? syn_rx_byte : arx_byte;
  wire stat_wr = wr_en && hit_stat;
  wire txbyte_wr = wr_en && hit_txbyte;
  wire rxbyte_rd = rd_done && hit_rxbyte;
  wire overrun = rx_got && stat_ff[ST_RX_FULL];

  always_comb begin
    nxt_stat = stat_ff;
    // Software clears flags 7 to 3 by writing zero to them
    if (stat_wr) begin
      nxt_stat[7:3] = stat_ff[7:3] & pwdata[7:3];
      nxt_stat[ST_MULTI_TX] = pwdata[ST_MULTI_TX];
    end
    if (txbyte_wr || tx_load) begin
      nxt_stat[ST_TX_EMPTY] = 1'b0;
    end
    if (tx_load) begin
      nxt_stat[ST_TX_EMPTY] = 1'b1;
      nxt_stat[ST_TX_DONE] = 1'b0;
    end
    if (tx_end && (stat_ff[ST_TX_EMPTY] || tx_load)) begin
      nxt_stat[ST_TX_DONE] = 1'b1;
    end
    // A byte arriving in the read cycle keeps the flag set
    if (rxbyte_rd && !rx_got) begin
      nxt_stat[ST_RX_FULL] = 1'b0;
    end
    if (rx_got && !stat_ff[ST_RX_FULL]) begin
      nxt_stat[ST_RX_FULL] = 1'b1;
      nxt_stat[ST_MULTI_RX] = multi_en & arx_extra;
    end
    if (overrun) begin
      nxt_stat[ST_OVERRUN] = 1'b1;
    end
    if (arx_done && arx_ferr) begin
      nxt_stat[ST_FRAME_ERR] = 1'b1;
    end
    if (arx_done && arx_perr) begin
      nxt_stat[ST_PARITY_ERR] = 1'b1;
    end
  end

  // ************************************************************
  // Register file writes
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_RST;
      div_ff <= DIV_RST;
      ctrl_ff <= CTRL_RST;
      order_ff <= ORDER_RST;
      pdir_ff <= PORT_RST;
      pfn3_ff <= PORT_RST;
      pfn2_ff <= PORT_RST;
    end else if (wr_en) begin
      if (hit_mode) mode_ff <= pwdata[7:0];
      if (hit_div) div_ff <= pwdata[7:0];
      if (hit_ctrl) ctrl_ff <= pwdata[7:0];
      if (hit_order) order_ff <= pwdata[7:0];
      if (hit_pdir) pdir_ff <= pwdata[15:0];
      if (hit_pfn3) pfn3_ff <= pwdata[15:0];
      if (hit_pfn2) pfn2_ff <= pwdata[15:0];
    end
  end

  // Data registers and flags; the older byte survives an overrun
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txbyte_ff <= BYTE_RST;
      rxbyte_ff <= 8'h00;
      stat_ff <= STAT_RST;
      prdata_ff <= 32'h0;
    end else begin
      if (txbyte_wr) txbyte_ff <= pwdata[7:0];
      if (rx_got && !stat_ff[ST_RX_FULL]) rxbyte_ff <= rx_byte;
      stat_ff <= nxt_stat;
      if (setup_ph) prdata_ff <= rd_mux;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  assign serial_tx_pin = sync_mode ? syn_tx_ff[0] : atx_shift_ff[0];
  assign serial_tx_oe = pin_serial[1];
  assign serial_clock_out = syn_sck_ff;
  assign serial_clock_oe = pin_serial[2] && sck_out_dir && sync_mode;

endmodule

// ### dv/serial_if_checker.sv
/* Port checker for serial_if.
   Assumes divider 9 with clock select 00 while frames run. */
`timescale 1ns/1ps
module serial_if_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_tx_pin,
  input wire logic serial_clock_out
);
  // ************************************************
  // Serial clock run lengths
  // ************************************************
  logic [7:0] hi_ff; // High run, saturating
  logic [7:0] lo_ff; // Low run, saturating
  logic [7:0] rise_ff; // Rises since the clock last idled
  // Counters, since a repetition cannot reach twenty cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_ff <= 8'h00;
      lo_ff <= 8'h00;
      rise_ff <= 8'h00;
    end else begin
      hi_ff <= serial_clock_out ? hi_ff + 8'(hi_ff != 8'hFF) : 8'h00;
      lo_ff <= serial_clock_out ? 8'h00 : lo_ff + 8'(lo_ff != 8'hFF);
      rise_ff <= (hi_ff > 8'h5A) ? 8'h00 : rise_ff + 8'($rose(serial_clock_out));
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready late");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_rdata_setup: assert property ($changed(prdata) |-> $past(psel) && !$past(penable))
    else $error("prdata moved outside setup");
  a_low_half: assert property ($rose(serial_clock_out) |-> lo_ff == 8'h14)
    else $error("clock low phase length");
  a_high_half: assert property
    ($fell(serial_clock_out) && rise_ff[2:0] != 3'h0 |-> hi_ff == 8'h14)
    else $error("clock high phase length");
  a_byte_eight: assert property (hi_ff == 8'h5A |-> rise_ff[2:0] == 3'h0)
    else $error("burst not whole bytes");
  a_data_hold: assert property ($rose(serial_clock_out) |=> $stable(serial_tx_pin))
    else $error("tx moved after rise");
endmodule
bind serial_if serial_if_checker u_serial_if_checker (.core_clk, .rst, .psel, .penable,
  .prdata, .pready, .pslverr, .serial_tx_pin, .serial_clock_out);

// ### dv/sync_peer.sv
/* Clocked synchronous serial peer.
   Assumes the device drives the serial clock. */
`timescale 1ns/1ps
module sync_peer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial lines
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // Bench side
  input wire logic [7:0] next_byte,
  output logic [7:0] got,
  output logic [7:0] nbytes
);
  // ************************************************
  // Shift on the device clock, LSB first
  // ************************************************
  logic sck_ff; // Last clock level
  logic [2:0] bit_ff; // Bits taken in this byte
  logic [7:0] cap_ff; // Capture shifter
  logic [7:0] out_ff; // Send shifter
  // Take on rise, present on fall so data is settled well before the rise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {bit_ff, cap_ff, out_ff, got, nbytes} <= '0;
      {sck_ff, sdi} <= 2'b11;
    end else begin
      sck_ff <= sck;
      if (sck && !sck_ff) begin
        cap_ff <= {sdo, cap_ff[7:1]};
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
          got <= {sdo, cap_ff[7:1]};
          nbytes <= nbytes + 8'h01;
        end
      end
      if (!sck && sck_ff) begin
        sdi <= (bit_ff == 3'h0) ? next_byte[0] : out_ff[0];
        out_ff <= (bit_ff == 3'h0) ? next_byte >> 1 : out_ff >> 1;
      end
    end
  end
endmodule

// ### dv/serial_if_tb.sv
/* Bench for serial_if: registers over APB, then bytes against
   the peer. Assumes the internal serial clock is driven out. */
`timescale 1ns/1ps
module serial_if_tb;
  import serial_if_pkg::*;
  // ************************************************
  // Signals, instances and helpers
  // ************************************************
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, tx_pin, tx_oe, ck_out, ck_oe, rx_pin;
  logic [7:0] peer_next = 8'h00, got, nbytes, a, b;
  int errors = 0, compares = 0, seed = 32'h9CE2D8A4;
  logic [31:0] ra [10] = '{IDX_MODE, IDX_DIV, IDX_CTRL, IDX_TXBYTE, IDX_STAT, IDX_RXBYTE,
    IDX_ORDER, IDX_PDIR, IDX_PFN3, IDX_PFN2};
  logic [31:0] rv [10] = '{32'(MODE_RST), 32'(DIV_RST), 32'(CTRL_RST), 32'(BYTE_RST),
    32'(STAT_RST), 32'h0, 32'(ORDER_RST), 32'(PORT_RST), 32'(PORT_RST), 32'(PORT_RST)};
  serial_if u_serial_if (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
    .serial_tx_oe(tx_oe), .serial_clock_in(1'b1), .serial_clock_out(ck_out),
    .serial_clock_oe(ck_oe));
  sync_peer u_sync_peer (.core_clk, .rst, .sck(ck_out), .sdo(tx_pin), .sdi(rx_pin),
    .next_byte(peer_next), .got, .nbytes);
  initial forever #5 core_clk = ~core_clk;
  task automatic final_report();
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the byte address is four times the index
  task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int bitno);
    apb(1'b0, IDX_STAT, 32'h0);
    for (int i = 0; i < 60 && rd[bitno] !== 1'b1; i++) apb(1'b0, IDX_STAT, 32'h0);
    chk("status flag", 32'h1, {31'h0, rd[bitno]});
  endtask
  task automatic xfer(input logic [7:0] t, input logic [7:0] r);
    logic [7:0] n0;
    n0 = nbytes;
    peer_next <= r;
    apb(1'b1, IDX_TXBYTE, {24'h0, t});
    for (int i = 0; i < 600 && nbytes === n0; i++) @(posedge core_clk);
    chk("peer count", {24'h0, n0 + 8'h01}, {24'h0, nbytes});
    chk("peer byte", {24'h0, t}, {24'h0, got});
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 32'h0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, IDX_PFN3, 32'h7);
    apb(1'b1, IDX_PFN2, 32'h2A);
    apb(1'b1, IDX_PDIR, 32'h4);
    apb(1'b1, IDX_DIV, 32'h9);
    apb(1'b1, IDX_MODE, 32'h80);
    apb(1'b0, IDX_MODE, 32'h0);
    chk("mode readback", 32'h80, rd);
    apb(1'b1, IDX_CTRL, 32'h30);
    chk("pin enables", 32'h3, {30'h0, tx_oe, ck_oe});
    repeat (4) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      xfer(a, b);
      poll(ST_RX_FULL);
      apb(1'b0, IDX_RXBYTE, 32'h0);
      chk("received byte", {24'h0, b}, rd);
    end
    // Two bytes with no read between: the first must survive
    xfer(8'h01, 8'h80);
    xfer(8'hFE, 8'h7F);
    poll(ST_OVERRUN);
    apb(1'b0, IDX_RXBYTE, 32'h0);
    chk("kept byte", 32'h80, rd);
    apb(1'b1, IDX_STAT, 32'hDF);
    apb(1'b0, IDX_STAT, 32'h0);
    chk("overrun cleared", 32'h0, {31'h0, rd[ST_OVERRUN]});
    apb(1'b1, IDX_CTRL, 32'h0);
    a = nbytes;
    apb(1'b1, IDX_TXBYTE, 32'h55);
    repeat (400) @(posedge core_clk);
    chk("idle when disabled", {24'h0, a}, {24'h0, nbytes});
    apb(1'b0, IDX_STAT, 32'h0);
    chk("tx empty", 32'h0, {31'h0, rd[ST_TX_EMPTY]});
    final_report();
  end
endmodule
